// ===== core/tpc_map.vh
// Register offsets, field positions and reset values of the transceiver pin control block
`ifndef TPC_MAP_VH
`define TPC_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TPC_ADDR_USER_CTRL 8'h00
`define TPC_ADDR_OEM_CFG3 8'h04
`define TPC_ADDR_PIN_STATUS 8'h08
`define TPC_ADDR_DROP_THR 8'h0C
`define TPC_ADDR_EVT_STATUS 8'h10
`define TPC_ADDR_EVT_MASK 8'h14

// ----------------------------------------------------------------
// user_control_reg fields
// ----------------------------------------------------------------
`define TPC_UC_SOFT_TX_OFF 0
`define TPC_UC_SOFT_RATE_SEL 1
`define TPC_UC_PIN_INT_EN 4
`define TPC_UC_WIDTH 5
`define TPC_UC_RESET 5'h00

// ----------------------------------------------------------------
// oem_config_three fields
// ----------------------------------------------------------------
`define TPC_OC_GPO_MODE 0
`define TPC_OC_PUSH_PULL 1
`define TPC_OC_GPO_LEVEL 2
`define TPC_OC_WIDTH 3
`define TPC_OC_RESET 3'h0

// ----------------------------------------------------------------
// Pin status fields
// ----------------------------------------------------------------
`define TPC_PS_TX_OFF 0
`define TPC_PS_RATE_SEL 1
`define TPC_PS_DROPOUT 2
`define TPC_PS_TX_FAULT 3
`define TPC_PS_TX_DISABLED 4
`define TPC_PS_WIDTH 5

// ----------------------------------------------------------------
// Event status and mask fields
// ----------------------------------------------------------------
`define TPC_EV_DROPOUT 0
`define TPC_EV_TX_FAULT 1
`define TPC_EV_TX_OFF 2
`define TPC_EV_RATE_SEL 3
`define TPC_EV_WIDTH 4
`define TPC_EV_RESET 4'h0

// ----------------------------------------------------------------
// Dropout threshold and synchronised pin indices
// ----------------------------------------------------------------
`define TPC_THR_RESET 16'h0000
`define TPC_LANE_LOW 0
`define TPC_LANE_HIGH 1
`define TPC_BYTE_MSB 7
`define TPC_HIGH_BYTE_LSB 8
`define TPC_SY_TX_OFF 0
`define TPC_SY_RATE_SEL 1
`define TPC_SY_DROPOUT 2
`define TPC_SY_TX_FAULT 3
`define TPC_SY_SER_CLK 4
`define TPC_SY_SER_DATA 5
`define TPC_SY_WIDTH 6

`endif

// ===== core/tpc_pin_ctrl.v
// Transceiver pin control: transmit-off, rate select, receive dropout, fault and interrupt pins
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "tpc_map.vh"

module tpc_pin_ctrl
#(
   parameter THR_WIDTH = 16
)
(
   input wire clk_i,
   input wire rst_i,
   // Wishbone classic slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Transmit control
   input wire transmit_off_in_i,
   output reg tx_shutdown_o,
   // Transmit fault from internal monitors and the fault wire
   input wire fault_detect_i,
   input wire transmit_fault_out_i,
   output reg transmit_fault_out_o,
   output reg transmit_fault_out_oe_o,
   // Rate select / general output
   input wire rate_select_in_i,
   output reg rate_select_out_o,
   output reg rate_select_out_oe_o,
   // Receive dropout
   input wire [THR_WIDTH-1:0] rx_power_level_i,
   input wire rx_signal_dropout_i,
   output reg rx_signal_dropout_o,
   output reg rx_signal_dropout_oe_o,
   // Dual-use supply sense / interrupt pin
   output reg supply_sense_pin_o,
   output reg supply_sense_pin_oe_o,
   output reg supply_sense_analog_o,
   // Serial management link pins
   input wire serial_clk_i,
   input wire serial_data_i,
   input wire serial_drive_low_i,
   output reg serial_data_o,
   output reg serial_data_oe_o,
   output wire serial_clk_sync_o,
   output wire serial_data_sync_o,
   // Interrupt
   output wire irq_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg [`TPC_UC_WIDTH-1:0] user_control_reg;
   reg [`TPC_OC_WIDTH-1:0] oem_config_three;
   reg [THR_WIDTH-1:0] dropout_threshold;
   reg [`TPC_EV_WIDTH-1:0] evt_status;
   reg [`TPC_EV_WIDTH-1:0] evt_mask;
   reg [`TPC_EV_WIDTH-1:0] next_evt_status;
   reg [`TPC_EV_WIDTH-1:0] evt_pulse;
   reg [`TPC_EV_WIDTH-1:0] evt_clear;
   reg [`TPC_PS_WIDTH-1:0] pin_status;
   reg [`TPC_PS_WIDTH-1:0] pin_status_d;
   reg [31:0] next_rdata;
   reg dropout_flag;
   reg next_dropout_flag;
   reg rate_or;
   wire [`TPC_SY_WIDTH-1:0] pin_async;
   wire [`TPC_SY_WIDTH-1:0] pin_sync;
   wire bus_req;
   wire bus_wr;
   wire irq_any;
   reg irq_state;

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   assign pin_async = {serial_data_i, serial_clk_i, transmit_fault_out_i,
                       rx_signal_dropout_i, rate_select_in_i, transmit_off_in_i};

   // Outside pins are only ever read through the synchroniser
   tpc_sync #(
      .WIDTH(`TPC_SY_WIDTH)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(pin_async),
      .sync_o(pin_sync)
   );

   assign serial_clk_sync_o = pin_sync[`TPC_SY_SER_CLK];
   assign serial_data_sync_o = pin_sync[`TPC_SY_SER_DATA];

   // ----------------------------------------------------------------
   // Pin status word
   // ----------------------------------------------------------------
   always @*
   begin
      pin_status = {`TPC_PS_WIDTH{1'b0}};
      pin_status[`TPC_PS_TX_OFF] = pin_sync[`TPC_SY_TX_OFF];
      pin_status[`TPC_PS_RATE_SEL] = pin_sync[`TPC_SY_RATE_SEL];
      pin_status[`TPC_PS_DROPOUT] = pin_sync[`TPC_SY_DROPOUT];
      pin_status[`TPC_PS_TX_FAULT] = pin_sync[`TPC_SY_TX_FAULT];
      pin_status[`TPC_PS_TX_DISABLED] = tx_shutdown_o;
   end

   // ----------------------------------------------------------------
   // Receive dropout comparator
   // ----------------------------------------------------------------
   // Equal power keeps the present state
   always @*
   begin
      next_dropout_flag = dropout_flag;
      if (rx_power_level_i < dropout_threshold)
      begin
         next_dropout_flag = 1'b1;
      end
      else if (rx_power_level_i > dropout_threshold)
      begin
         next_dropout_flag = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   always @*
   begin
      rate_or = user_control_reg[`TPC_UC_SOFT_RATE_SEL] | pin_sync[`TPC_SY_RATE_SEL];
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dropout_flag <= 1'b0;
         tx_shutdown_o <= 1'b0;
         transmit_fault_out_o <= 1'b0;
         transmit_fault_out_oe_o <= 1'b1;
         rate_select_out_o <= 1'b0;
         rate_select_out_oe_o <= 1'b1;
         rx_signal_dropout_o <= 1'b0;
         rx_signal_dropout_oe_o <= 1'b1;
         supply_sense_pin_o <= 1'b0;
         supply_sense_pin_oe_o <= 1'b0;
         supply_sense_analog_o <= 1'b1;
         serial_data_o <= 1'b0;
         serial_data_oe_o <= 1'b0;
      end
      else
      begin
         dropout_flag <= next_dropout_flag;
         tx_shutdown_o <= pin_sync[`TPC_SY_TX_OFF] | user_control_reg[`TPC_UC_SOFT_TX_OFF];
         // Open-drain fault line: pull low when healthy, release on fault
         transmit_fault_out_o <= 1'b0;
         transmit_fault_out_oe_o <= ~fault_detect_i;
         // Open-drain dropout line, wire-OR with external drivers
         rx_signal_dropout_o <= 1'b0;
         rx_signal_dropout_oe_o <= ~dropout_flag;
         if (oem_config_three[`TPC_OC_GPO_MODE])
         begin
            if (oem_config_three[`TPC_OC_PUSH_PULL])
            begin
               rate_select_out_o <= oem_config_three[`TPC_OC_GPO_LEVEL];
               rate_select_out_oe_o <= 1'b1;
            end
            else
            begin
               rate_select_out_o <= 1'b0;
               rate_select_out_oe_o <= ~oem_config_three[`TPC_OC_GPO_LEVEL];
            end
         end
         else
         begin
            rate_select_out_o <= 1'b0;
            rate_select_out_oe_o <= ~rate_or;
         end
         // Dual-use pin: analog input or open-drain active-low interrupt
         supply_sense_analog_o <= ~user_control_reg[`TPC_UC_PIN_INT_EN];
         supply_sense_pin_o <= 1'b0;
         supply_sense_pin_oe_o <= user_control_reg[`TPC_UC_PIN_INT_EN] & irq_any;
         // Serial data only ever pulls low
         serial_data_o <= 1'b0;
         serial_data_oe_o <= serial_drive_low_i;
      end
   end

   // ----------------------------------------------------------------
   // Event capture
   // ----------------------------------------------------------------
   // Delayed copy resets to the idle level of each pin, so reset makes no false event
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_status_d <= {`TPC_PS_WIDTH{1'b0}};
      end
      else
      begin
         pin_status_d <= pin_status;
      end
   end

   always @*
   begin
      evt_pulse = {`TPC_EV_WIDTH{1'b0}};
      evt_pulse[`TPC_EV_DROPOUT] = pin_status[`TPC_PS_DROPOUT] & ~pin_status_d[`TPC_PS_DROPOUT];
      evt_pulse[`TPC_EV_TX_FAULT] = pin_status[`TPC_PS_TX_FAULT] & ~pin_status_d[`TPC_PS_TX_FAULT];
      evt_pulse[`TPC_EV_TX_OFF] = pin_status[`TPC_PS_TX_OFF] ^ pin_status_d[`TPC_PS_TX_OFF];
      evt_pulse[`TPC_EV_RATE_SEL] = pin_status[`TPC_PS_RATE_SEL] ^ pin_status_d[`TPC_PS_RATE_SEL];
   end

   // ----------------------------------------------------------------
   // Wishbone access
   // ----------------------------------------------------------------
   // Ack blocks a second take while the master still holds its strobe
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i;

   always @*
   begin
      evt_clear = {`TPC_EV_WIDTH{1'b0}};
      if (bus_wr && wb_adr_i == `TPC_ADDR_EVT_STATUS && wb_sel_i[`TPC_LANE_LOW])
      begin
         evt_clear = wb_dat_i[`TPC_EV_WIDTH-1:0];
      end
      // A new event wins over a clear in the same cycle
      next_evt_status = (evt_status & ~evt_clear) | evt_pulse;
   end

   always @*
   begin
      next_rdata = 32'h0000_0000;
      if (wb_adr_i == `TPC_ADDR_USER_CTRL)
      begin
         next_rdata[`TPC_UC_WIDTH-1:0] = user_control_reg;
      end
      else if (wb_adr_i == `TPC_ADDR_OEM_CFG3)
      begin
         next_rdata[`TPC_OC_WIDTH-1:0] = oem_config_three;
      end
      else if (wb_adr_i == `TPC_ADDR_PIN_STATUS)
      begin
         next_rdata[`TPC_PS_WIDTH-1:0] = pin_status;
      end
      else if (wb_adr_i == `TPC_ADDR_DROP_THR)
      begin
         next_rdata[THR_WIDTH-1:0] = dropout_threshold;
      end
      else if (wb_adr_i == `TPC_ADDR_EVT_STATUS)
      begin
         next_rdata[`TPC_EV_WIDTH-1:0] = evt_status;
      end
      else if (wb_adr_i == `TPC_ADDR_EVT_MASK)
      begin
         next_rdata[`TPC_EV_WIDTH-1:0] = evt_mask;
      end
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         user_control_reg <= `TPC_UC_RESET;
         oem_config_three <= `TPC_OC_RESET;
         dropout_threshold <= `TPC_THR_RESET;
         evt_status <= `TPC_EV_RESET;
         evt_mask <= `TPC_EV_RESET;
      end
      else
      begin
         wb_ack_o <= bus_req;
         // Read data stands only in the ack cycle
         wb_dat_o <= bus_req ? next_rdata : 32'h0000_0000;
         evt_status <= next_evt_status;
         if (bus_wr && wb_sel_i[`TPC_LANE_LOW])
         begin
            if (wb_adr_i == `TPC_ADDR_USER_CTRL)
            begin
               user_control_reg <= wb_dat_i[`TPC_UC_WIDTH-1:0];
            end
            else if (wb_adr_i == `TPC_ADDR_OEM_CFG3)
            begin
               oem_config_three <= wb_dat_i[`TPC_OC_WIDTH-1:0];
            end
            else if (wb_adr_i == `TPC_ADDR_EVT_MASK)
            begin
               evt_mask <= wb_dat_i[`TPC_EV_WIDTH-1:0];
            end
         end
         // Threshold is written per byte lane, both bytes in one access when both lanes are selected
         if (bus_wr && wb_adr_i == `TPC_ADDR_DROP_THR)
         begin
            if (wb_sel_i[`TPC_LANE_LOW])
            begin
               dropout_threshold[`TPC_BYTE_MSB:0] <= wb_dat_i[`TPC_BYTE_MSB:0];
            end
            if (wb_sel_i[`TPC_LANE_HIGH])
            begin
               dropout_threshold[THR_WIDTH-1:`TPC_HIGH_BYTE_LSB] <= wb_dat_i[THR_WIDTH-1:`TPC_HIGH_BYTE_LSB];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   assign irq_any = |(evt_status & evt_mask);

   // Registered so the interrupt output and the dual-use pin change on the same edge
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_state <= 1'b0;
      end
      else
      begin
         irq_state <= irq_any;
      end
   end

   assign irq_o = irq_state;

endmodule // tpc_pin_ctrl

// ===== core/tpc_sync.v
// Two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps

module tpc_sync
#(
   parameter WIDTH = 6
)
(
   input wire clk_i,
   input wire rst_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] stage_one;
   reg [WIDTH-1:0] stage_two;

   // ----------------------------------------------------------------
   // First stage is read only by the second stage
   // ----------------------------------------------------------------
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stage_one <= {WIDTH{1'b0}};
         stage_two <= {WIDTH{1'b0}};
      end
      else
      begin
         stage_one <= async_i;
         stage_two <= stage_one;
      end
   end

   assign sync_o = stage_two;

endmodule // tpc_sync

// ===== sim/tb_top.sv
// Self-checking testbench for the transceiver pin control block
`timescale 1ns/1ps

module tb_top;
   logic clk_i;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, rdat;
   logic transmit_off_in_i = 1'b0, fault_detect_i = 1'b0, rate_select_in_i = 1'b0;
   logic [15:0] rx_power_level_i = 16'h0200;
   logic serial_clk_i = 1'b1, serial_drive_low_i = 1'b0, drop_low = 1'b0, fault_low = 1'b0, host_low = 1'b0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, tx_shutdown_o, transmit_fault_out_i, transmit_fault_out_o, transmit_fault_out_oe_o;
   wire rate_select_out_o, rate_select_out_oe_o, rx_signal_dropout_i, rx_signal_dropout_o, rx_signal_dropout_oe_o;
   wire supply_sense_pin_o, supply_sense_pin_oe_o, supply_sense_analog_o, serial_data_i, serial_data_o;
   wire serial_data_oe_o, serial_clk_sync_o, serial_data_sync_o, irq_o, rate_wire, sup_wire;
   integer err_count = 0, n_tests = 0;

   tpc_pin_ctrl #(.THR_WIDTH(16)) i_tpc_pin_ctrl (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .transmit_off_in_i, .tx_shutdown_o, .fault_detect_i,
      .transmit_fault_out_i, .transmit_fault_out_o, .transmit_fault_out_oe_o, .rate_select_in_i,
      .rate_select_out_o, .rate_select_out_oe_o, .rx_power_level_i, .rx_signal_dropout_i, .rx_signal_dropout_o,
      .rx_signal_dropout_oe_o, .supply_sense_pin_o, .supply_sense_pin_oe_o, .supply_sense_analog_o, .serial_clk_i,
      .serial_data_i, .serial_drive_low_i, .serial_data_o, .serial_data_oe_o, .serial_clk_sync_o,
      .serial_data_sync_o, .irq_o);

   tpc_host_model i_tpc_host_model (.drop_oe_i(rx_signal_dropout_oe_o), .drop_low_i(drop_low),
      .fault_oe_i(transmit_fault_out_oe_o), .fault_low_i(fault_low), .rate_oe_i(rate_select_out_oe_o),
      .rate_i(rate_select_out_o), .sup_oe_i(supply_sense_pin_oe_o), .sda_oe_i(serial_data_oe_o),
      .host_low_i(host_low), .drop_o(rx_signal_dropout_i), .fault_o(transmit_fault_out_i), .rate_o(rate_wire),
      .sup_o(sup_wire), .sda_o(serial_data_i));

   // ----------------------------------------------------------------
   // Bus cycles and comparisons
   // ----------------------------------------------------------------
   task tick(input integer k);
      repeat (k) @(posedge clk_i);
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp)
         begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask

   task bus(input w, input [7:0] a, input [31:0] d, input [3:0] s);
      begin
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         wb_sel_i <= s;
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         @(posedge clk_i);
         while (wb_ack_o !== 1'b1)
         begin
            @(posedge clk_i);
         end
         rdat = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task rc(input [7:0] a, input [31:0] e);
      begin
         bus(1'b0, a, 32'h0, 4'hF);
         chk(rdat, e);
      end
   endtask

   task stop_test;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, err_count);
         if (err_count == 0 && n_tests > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_reset;
      integer i;
      begin
         for (i = 0; i < 7; i = i + 1)
            rc(8'(i * 4), 32'h0);
         chk(supply_sense_analog_o, 1'b1);
         bus(1'b1, 8'h00, 32'h1, 4'hE);
         tick(2);
         chk(tx_shutdown_o, 1'b0);
         $display("reset values done");
      end
   endtask

   task t_txoff;
      begin
         transmit_off_in_i <= 1'b1;
         tick(3);
         chk(tx_shutdown_o, 1'b0);
         tick(1);
         chk(tx_shutdown_o, 1'b1);
         rc(8'h08, 32'h11);
         transmit_off_in_i <= 1'b0;
         tick(5);
         wr(8'h00, 32'h1);
         tick(2);
         chk(tx_shutdown_o, 1'b1);
         rc(8'h08, 32'h10);
         wr(8'h00, 32'h0);
         $display("transmit off done");
      end
   endtask

   task t_rate;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1)
         begin
            rate_select_in_i <= i[0];
            wr(8'h00, {30'h0, i[1], 1'b0});
            tick(4);
            chk(rate_wire, i[0] | i[1]);
            rc(8'h08, {30'h0, i[0], 1'b0});
         end
         rate_select_in_i <= 1'b0;
         wr(8'h00, 32'h0);
         for (i = 0; i < 4; i = i + 1)
         begin
            wr(8'h04, {29'h0, i[1], i[0], 1'b1});
            tick(3);
            chk(rate_wire, i[1]);
            chk(rate_select_out_oe_o, i[0] | !i[1]);
         end
         wr(8'h04, 32'h0);
         $display("rate select done");
      end
   endtask

   task t_drop;
      begin
         wr(8'h0C, 32'h0100);
         rx_power_level_i <= 16'h0080;
         tick(5);
         chk(rx_signal_dropout_i, 1'b1);
         rc(8'h08, 32'h4);
         rx_power_level_i <= 16'h0100;
         tick(5);
         chk(rx_signal_dropout_i, 1'b1);
         drop_low <= 1'b1;
         tick(5);
         rc(8'h08, 32'h0);
         drop_low <= 1'b0;
         rx_power_level_i <= 16'h0101;
         tick(5);
         chk(rx_signal_dropout_i, 1'b0);
         fault_detect_i <= 1'b1;
         tick(5);
         chk(transmit_fault_out_i, 1'b1);
         rc(8'h08, 32'h8);
         fault_low <= 1'b1;
         tick(5);
         rc(8'h08, 32'h0);
         fault_low <= 1'b0;
         fault_detect_i <= 1'b0;
         $display("dropout and fault done");
      end
   endtask

   task t_irq;
      begin
         rc(8'h10, 32'hF);
         wr(8'h14, 32'h1);
         chk(irq_o, 1'b1);
         chk(sup_wire, 1'b1);
         wr(8'h00, 32'h10);
         tick(3);
         chk(supply_sense_analog_o, 1'b0);
         chk(sup_wire, 1'b0);
         wr(8'h10, 32'h1);
         tick(3);
         chk(irq_o, 1'b0);
         chk(sup_wire, 1'b1);
         rc(8'h10, 32'hE);
         wr(8'h10, 32'hF);
         wr(8'h00, 32'h0);
         tick(3);
         chk(supply_sense_analog_o, 1'b1);
         $display("interrupt done");
      end
   endtask

   task t_serial;
      begin
         serial_drive_low_i <= 1'b1;
         serial_clk_i <= 1'b0;
         tick(5);
         chk(serial_data_sync_o, 1'b0);
         chk(serial_clk_sync_o, 1'b0);
         serial_drive_low_i <= 1'b0;
         serial_clk_i <= 1'b1;
         tick(5);
         chk(serial_data_sync_o, 1'b1);
         chk(serial_clk_sync_o, 1'b1);
         host_low <= 1'b1;
         tick(5);
         chk(serial_data_sync_o, 1'b0);
         host_low <= 1'b0;
         $display("serial pins done");
      end
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   initial
   begin
      #100000;
      err_count = err_count + 1;
      $display("wrong value at %0t: watchdog expired", $time);
      stop_test;
   end

   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      tick(3);
      t_reset;
      t_txoff;
      t_rate;
      t_drop;
      t_irq;
      t_serial;
      stop_test;
   end
endmodule // tb_top

bind tpc_pin_ctrl tpc_checker i_tpc_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
   .transmit_off_in_i, .tx_shutdown_o, .fault_detect_i, .transmit_fault_out_o, .transmit_fault_out_oe_o,
   .rx_signal_dropout_o, .supply_sense_pin_o, .supply_sense_pin_oe_o, .supply_sense_analog_o,
   .serial_drive_low_i, .serial_data_o, .serial_data_oe_o, .irq_o);

// ===== sim/tpc_checker.sv
// Concurrent checks on the ports of the transceiver pin control block
`timescale 1ns/1ps

module tpc_checker (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire transmit_off_in_i,
   input wire tx_shutdown_o,
   input wire fault_detect_i,
   input wire transmit_fault_out_o,
   input wire transmit_fault_out_oe_o,
   input wire rx_signal_dropout_o,
   input wire supply_sense_pin_o,
   input wire supply_sense_pin_oe_o,
   input wire supply_sense_analog_o,
   input wire serial_drive_low_i,
   input wire serial_data_o,
   input wire serial_data_oe_o,
   input wire irq_o
);
   // ----------------------------------------------------------------
   // Port relations
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   AST_DAT_ZERO: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack cycle");
   AST_TX_ON: assert property (transmit_off_in_i [*3] |=> tx_shutdown_o)
      else $error("transmitter not shut down by pin");
   AST_TX_REL: assert property ($fell(tx_shutdown_o) |-> !$past(transmit_off_in_i, 3))
      else $error("shutdown released while pin high");
   AST_OD_LOW: assert property (!(transmit_fault_out_o || rx_signal_dropout_o || supply_sense_pin_o || serial_data_o))
      else $error("open-drain pin driven high");
   AST_SENSE_MODE: assert property (supply_sense_pin_oe_o |-> !supply_sense_analog_o)
      else $error("dual-use pin driven in analog mode");
   AST_INT_ON: assert property ((!supply_sense_analog_o && irq_o) [*2] |-> supply_sense_pin_oe_o)
      else $error("interrupt pin not pulled low");
   AST_INT_OFF: assert property ((!irq_o) [*2] |-> !supply_sense_pin_oe_o)
      else $error("interrupt pin pulled without interrupt");
   AST_SER_OE: assert property (serial_data_oe_o == $past(serial_drive_low_i))
      else $error("serial data drive does not follow request");
   AST_FAULT: assert property (fault_detect_i [*2] |-> !transmit_fault_out_oe_o)
      else $error("fault line not released on fault");

   cover property (wb_ack_o && wb_cyc_i);
   cover property ($rose(tx_shutdown_o));
   cover property ($rose(supply_sense_pin_oe_o));
endmodule // tpc_checker

// ===== sim/tpc_host_model.sv
// Host side of the pins: pull-ups, external wire-OR drivers and serial data
`timescale 1ns/1ps

module tpc_host_model (
   input wire drop_oe_i,
   input wire drop_low_i,
   input wire fault_oe_i,
   input wire fault_low_i,
   input wire rate_oe_i,
   input wire rate_i,
   input wire sup_oe_i,
   input wire sda_oe_i,
   input wire host_low_i,
   output wire drop_o,
   output wire fault_o,
   output wire rate_o,
   output wire sup_o,
   output wire sda_o
);
   // ----------------------------------------------------------------
   // Wire levels with pull-ups
   // ----------------------------------------------------------------
   assign drop_o = !(drop_oe_i || drop_low_i);
   assign fault_o = !(fault_oe_i || fault_low_i);
   assign rate_o = rate_oe_i ? rate_i : 1'b1;
   assign sup_o = !sup_oe_i;
   assign sda_o = !(sda_oe_i || host_low_i);
endmodule // tpc_host_model
